// ===== hdl/ops_pkg.sv
// shared constants and carriers for the unsigned compare and convert unit
package ops_pkg;
  localparam int DATA_W = 32;
  localparam int DEST_W = 7;
  localparam int MOD_W = 7;
  localparam int OPC_W = 8;
  localparam int SLOT_W = 3;
  localparam int FLAG_W = 6;
  localparam int MANT_W = 23;
  localparam int MSB_W = 5;
  localparam logic [OPC_W-1:0] OPC_UFLOATRZ = 8'h77;
  localparam logic [OPC_W-1:0] OPC_UFLOATRZFLAGS = 8'h78;
  localparam logic [OPC_W-1:0] OPC_UGTRI = 8'h22;
  localparam logic [OPC_W-1:0] OPC_UGEQ = 8'h1E;
  localparam logic [OPC_W-1:0] OPC_UGEQI = 8'h1F;
  localparam logic [OPC_W-1:0] OPC_UGTR = 8'h21;
  localparam int FLG_INEXACT = 1;
  localparam int FLG_INV = 4;
  localparam int FLG_IFZ = 5;
  localparam logic [7:0] EXP_BIAS = 8'h7F;
  localparam logic [SLOT_W-1:0] SLOT_FALU_A = 3'h1;
  localparam logic [SLOT_W-1:0] SLOT_FALU_B = 3'h4;
  localparam logic [SLOT_W-1:0] SLOT_ALU_MIN = 3'h1;
  localparam logic [SLOT_W-1:0] SLOT_ALU_MAX = 3'h5;
  localparam logic [FLAG_W-1:0] PSW_FLAGS_RST = 6'h00;

  typedef enum logic [2:0] {
    K_NONE = 3'b000,
    K_UGEQ = 3'b001,
    K_UGEQI = 3'b010,
    K_UGTR = 3'b011,
    K_UGTRI = 3'b100,
    K_FCONV = 3'b101,
    K_FFLAGS = 3'b110
  } opkind_t;

  typedef struct packed {
    logic valid;
    logic [OPC_W-1:0] opcode;
    logic [SLOT_W-1:0] slot;
    logic guard_en;
    logic guard_lsb;
    logic [DEST_W-1:0] dest;
    logic [DATA_W-1:0] first_source_operand;
    logic [DATA_W-1:0] second_source_operand;
    logic [MOD_W-1:0] modifier;
  } issue_t;

  typedef struct packed {
    logic valid;
    logic [DEST_W-1:0] dest;
    logic [DATA_W-1:0] data;
  } wb_t;

  typedef struct packed {
    logic valid;
    logic set_psw;
    logic flags_only;
    logic [DEST_W-1:0] dest;
    logic [DATA_W-1:0] data;
    logic [FLAG_W-1:0] flags;
  } fstage_t;
endpackage

// ===== hdl/ufloat_rz.sv
// unsigned integer to single precision, truncating, with exception flags
`timescale 1ns/1ps
module ufloat_rz import ops_pkg::*; (
  input wire logic [DATA_W-1:0] value,
  output logic [DATA_W-1:0] result,
  output logic [FLAG_W-1:0] flags
);
  localparam logic [MSB_W-1:0] MSB_TOP = MSB_W'(DATA_W-1);
  logic [MSB_W-1:0] msb;
  logic [DATA_W-1:0] norm;
  logic [7:0] expo;
  logic inexact;

  always_comb begin
    msb = '0;
    for (int i = 0; i < DATA_W; i++) begin
      if (value[i]) begin
        msb = i[MSB_W-1:0];
      end
    end
  end

  assign norm = value << (MSB_TOP - msb);
  assign expo = EXP_BIAS + {3'h0, msb};
  // dropped bits are simply cut off, so rounding mode never matters
  assign inexact = |norm[DATA_W-MANT_W-2:0];
  assign result = (value == '0) ? '0 : {1'b0, expo, norm[DATA_W-2 -: MANT_W]};

  // unsigned source: overflow, invalid and underflow cannot arise
  always_comb begin
    flags = '0;
    flags[FLG_INEXACT] = inexact;
  end
endmodule

// ===== hdl/ucmp_conv_unit.sv
// unsigned compare and truncating convert execution unit
`timescale 1ns/1ps
module ucmp_conv_unit import ops_pkg::*; (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic CE,
  input wire issue_t ISSUE,
  input wire logic PSW_WR,
  input wire logic [FLAG_W-1:0] PSW_WFLAGS,
  output wb_t ALU_WB,
  output wb_t FALU_WB,
  output logic [FLAG_W-1:0] PROCESSOR_STATUS_WORD,
  output logic ILLEGAL_SLOT
);
  opkind_t kind;
  logic go;
  logic guard_ok;
  logic is_alu;
  logic is_falu;
  logic alu_slot_ok;
  logic falu_slot_ok;
  logic alu_wr;
  logic falu_wr;
  logic illegal_nxt;
  logic use_imm;
  logic want_ge;
  logic [DATA_W-1:0] opnd_b;
  logic cmp_ge;
  logic cmp_gt;
  logic cmp_bit;
  wb_t alu_r;
  wb_t alu_nxt;
  fstage_t s1_r;
  fstage_t s1_nxt;
  fstage_t s2_r;
  fstage_t s2_nxt;
  wb_t fout_r;
  wb_t fout_nxt;
  logic [FLAG_W-1:0] psw_r;
  logic [FLAG_W-1:0] psw_nxt;
  logic [FLAG_W-1:0] psw_set;
  logic illegal_r;
  logic [DATA_W-1:0] conv_result;
  logic [FLAG_W-1:0] conv_flags;

  // decode
  assign kind = (ISSUE.opcode == OPC_UGEQ) ? K_UGEQ :
                (ISSUE.opcode == OPC_UGEQI) ? K_UGEQI :
                (ISSUE.opcode == OPC_UGTR) ? K_UGTR :
                (ISSUE.opcode == OPC_UGTRI) ? K_UGTRI :
                (ISSUE.opcode == OPC_UFLOATRZ) ? K_FCONV :
                (ISSUE.opcode == OPC_UFLOATRZFLAGS) ? K_FFLAGS : K_NONE;
  assign go = CE & ISSUE.valid;
  assign guard_ok = ~ISSUE.guard_en | ISSUE.guard_lsb;
  assign is_alu = (kind == K_UGEQ) | (kind == K_UGEQI) | (kind == K_UGTR) | (kind == K_UGTRI);
  assign is_falu = (kind == K_FCONV) | (kind == K_FFLAGS);
  assign alu_slot_ok = (ISSUE.slot >= SLOT_ALU_MIN) & (ISSUE.slot <= SLOT_ALU_MAX);
  assign falu_slot_ok = (ISSUE.slot == SLOT_FALU_A) | (ISSUE.slot == SLOT_FALU_B);
  // a misplaced op is dropped whole; the scheduler is expected never to do it
  assign illegal_nxt = go & ((is_alu & ~alu_slot_ok) | (is_falu & ~falu_slot_ok));
  assign alu_wr = go & is_alu & alu_slot_ok & guard_ok;
  assign falu_wr = go & is_falu & falu_slot_ok & guard_ok;

  // compare: plain unsigned relations, no sign extension anywhere
  assign use_imm = (kind == K_UGEQI) | (kind == K_UGTRI);
  assign want_ge = (kind == K_UGEQ) | (kind == K_UGEQI);
  assign opnd_b = use_imm ? DATA_W'(ISSUE.modifier) : ISSUE.second_source_operand;
  assign cmp_ge = ISSUE.first_source_operand >= opnd_b;
  assign cmp_gt = ISSUE.first_source_operand > opnd_b;
  assign cmp_bit = want_ge ? cmp_ge : cmp_gt;
  assign alu_nxt = '{valid: alu_wr, dest: ISSUE.dest, data: {{(DATA_W-1){1'b0}}, cmp_bit}};

  // float pipe: operand in s1, conversion between s1 and s2, writeback after
  assign s1_nxt = '{valid: falu_wr, set_psw: kind == K_FCONV, flags_only: kind == K_FFLAGS,
                    dest: ISSUE.dest, data: ISSUE.first_source_operand, flags: '0};

  ufloat_rz conv (
    .value(s1_r.data),
    .result(conv_result),
    .flags(conv_flags)
  );

  assign s2_nxt = '{valid: s1_r.valid, set_psw: s1_r.set_psw, flags_only: s1_r.flags_only,
                    dest: s1_r.dest,
                    data: s1_r.flags_only ? {{(DATA_W-FLAG_W){1'b0}}, conv_flags} : conv_result,
                    flags: conv_flags};
  assign fout_nxt = '{valid: s2_r.valid, dest: s2_r.dest, data: s2_r.data};

  // sticky flags: set lands with the writeback and beats a same-cycle clear
  assign psw_set = (s2_r.valid & s2_r.set_psw) ? s2_r.flags : '0;
  assign psw_nxt = (PSW_WR ? PSW_WFLAGS : psw_r) | psw_set;

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      alu_r <= '0;
      s1_r <= '0;
      s2_r <= '0;
      fout_r <= '0;
      psw_r <= PSW_FLAGS_RST;
      illegal_r <= 1'b0;
    end else if (CE) begin
      alu_r <= alu_nxt;
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      fout_r <= fout_nxt;
      psw_r <= psw_nxt;
      illegal_r <= illegal_nxt;
    end
  end

  assign ALU_WB = alu_r;
  assign FALU_WB = fout_r;
  assign PROCESSOR_STATUS_WORD = psw_r;
  assign ILLEGAL_SLOT = illegal_r;

  // checks
  localparam logic [DATA_W-1:0] ALL_ONES = 32'hFFFFFFFF;
  localparam logic [DATA_W-1:0] RZ_ALL_ONES = 32'h4F7FFFFF;
  localparam logic [DATA_W-1:0] INEXACT_ONLY = DATA_W'(1) << FLG_INEXACT;
  logic fl_go;
  logic rz_go;
  assign fl_go = falu_wr & (kind == K_FFLAGS);
  assign rz_go = falu_wr & (kind == K_FCONV);

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESETN);

  a_ugeq_reg_result: assert property (alu_wr && kind == K_UGEQ |=>
    ALU_WB.valid && ALU_WB.data[0] == ($past(ISSUE.first_source_operand) >= $past(ISSUE.second_source_operand)))
    else $error("ugeq result wrong");

  a_ugeqi_imm_result: assert property (alu_wr && kind == K_UGEQI |=>
    ALU_WB.valid && ALU_WB.data[0] == ($past(ISSUE.first_source_operand) >= DATA_W'($past(ISSUE.modifier))))
    else $error("ugeqi result wrong");

  a_ugtr_reg_result: assert property (alu_wr && kind == K_UGTR |=>
    ALU_WB.valid && ALU_WB.data[0] == ($past(ISSUE.first_source_operand) > $past(ISSUE.second_source_operand)))
    else $error("ugtr result wrong");

  a_ugtri_imm_timing: assert property (alu_wr && kind == K_UGTRI |=>
    ALU_WB.valid && ALU_WB.dest == $past(ISSUE.dest) &&
    ALU_WB.data[0] == ($past(ISSUE.first_source_operand) > DATA_W'($past(ISSUE.modifier))))
    else $error("ugtri result or timing wrong");

  a_unsigned_top_bit: assert property (alu_wr && !want_ge && ISSUE.first_source_operand[DATA_W-1] &&
    !opnd_b[DATA_W-1] |=> ALU_WB.data[0])
    else $error("top bit compared as signed");

  a_cmp_upper_zero: assert property (ALU_WB.valid |-> ALU_WB.data[DATA_W-1:1] == '0)
    else $error("compare upper bits not zero");

  a_guard_no_write: assert property (go && ISSUE.guard_en && !ISSUE.guard_lsb |=> !ALU_WB.valid)
    else $error("guarded-off op wrote");

  a_guard_falu_none: assert property (go && is_falu && !guard_ok ##1 CE [*2] |=> !FALU_WB.valid)
    else $error("guarded-off float op wrote");

  a_flag_op_latency: assert property (fl_go ##1 CE [*2] |=>
    FALU_WB.valid && FALU_WB.dest == $past(ISSUE.dest, 3) && (FALU_WB.data & ~INEXACT_ONLY) == '0)
    else $error("flag op latency or layout wrong");

  a_flag_op_exact: assert property (fl_go && ISSUE.first_source_operand[DATA_W-1:MANT_W+1] == '0
    ##1 CE [*2] |=> FALU_WB.data == '0)
    else $error("exact conversion reported flags");

  a_rz_truncates: assert property (rz_go && ISSUE.first_source_operand == ALL_ONES ##1 CE [*2] |=>
    FALU_WB.data == RZ_ALL_ONES)
    else $error("conversion did not round toward zero");

  a_psw_hold: assert property (CE && !PSW_WR && psw_set == '0 |=> $stable(PROCESSOR_STATUS_WORD))
    else $error("status flags changed without cause");

  a_psw_sticky_or: assert property (CE && psw_set != '0 |=>
    (PROCESSOR_STATUS_WORD & $past(psw_set)) == $past(psw_set))
    else $error("converting op flags not merged");

  a_slot_reject: assert property (go && is_alu && !alu_slot_ok |=> ILLEGAL_SLOT && !ALU_WB.valid)
    else $error("misplaced compare not rejected");

  c_cmp_write: cover property (alu_wr ##1 ALU_WB.data[0]);
  c_flag_inexact: cover property (fl_go ##1 CE [*2] ##1 FALU_WB.data[FLG_INEXACT]);
  c_psw_set_clear: cover property (PSW_WR && psw_set != '0);
  c_guard_skip: cover property (go && !guard_ok && is_alu);
endmodule

// ===== bench/issue_model.sv
// issue slot and register file model feeding one operation at a time
`timescale 1ns/1ps
module issue_model import ops_pkg::*; (
  input wire logic CLOCK,
  output issue_t ISSUE
);
  initial ISSUE = '0;
  // operation held for exactly one taken edge
  task automatic send(input issue_t op);
    issue_t idle;
    idle = ~op;
    idle.valid = 1'b0;
    @(posedge CLOCK);
    ISSUE <= op;
    @(posedge CLOCK);
    // operands scrambled once released, so a design reading stale fields cannot pass
    ISSUE <= idle;
  endtask
endmodule

// ===== bench/tb_top.sv
// self-checking bench for the unsigned compare and convert unit
`timescale 1ns/1ps
module tb_top import ops_pkg::*;;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic psw_wr = 1'b0;
  logic [FLAG_W-1:0] psw_wflags = 6'h00;
  issue_t issue;
  wb_t alu_wb;
  wb_t falu_wb;
  logic [FLAG_W-1:0] psw;
  logic illegal_slot;
  int err_count = 0;
  int n_tests = 0;
  always #12.5 clock = ~clock;
  issue_model issue_model_inst (.CLOCK(clock), .ISSUE(issue));
  ucmp_conv_unit ucmp_conv_unit_inst (.CLOCK(clock), .RESETN(resetn), .CE(ce), .ISSUE(issue),
    .PSW_WR(psw_wr), .PSW_WFLAGS(psw_wflags), .ALU_WB(alu_wb), .FALU_WB(falu_wb),
    .PROCESSOR_STATUS_WORD(psw), .ILLEGAL_SLOT(illegal_slot));
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic issue_t op(input logic [7:0] opc, input logic [2:0] slot, input logic gl,
      input logic [31:0] a, input logic [31:0] b, input logic [6:0] m);
    op = '{1'b1, opc, slot, 1'b1, gl, m ^ 7'h55, a, b, m};
  endfunction
  task automatic cmp(input logic [7:0] opc, input logic [2:0] slot, input logic gl, input logic [31:0] a,
      input logic [31:0] b, input logic [6:0] m, input logic r);
    issue_model_inst.send(op(opc, slot, gl, a, b, m));
    #1;
    chk("alu valid", 32'(alu_wb.valid), 32'(gl));
    if (gl) begin
      chk("alu data", alu_wb.data, {31'h0, r});
      chk("alu dest", 32'(alu_wb.dest), 32'(m ^ 7'h55));
    end
    @(posedge clock);
    #1;
    chk("alu pulse", 32'(alu_wb.valid), 32'h0);
  endtask
  task automatic fop(input logic [7:0] opc, input logic [2:0] slot, input logic gl, input logic [31:0] a,
      input logic [31:0] r, input logic [5:0] p);
    logic ok;
    ok = (slot == 3'h1) || (slot == 3'h4);
    issue_model_inst.send(op(opc, slot, gl, a, 32'h0, 7'h00));
    #1;
    chk("slot refused", 32'(illegal_slot), 32'(!ok));
    @(posedge clock);
    @(posedge clock);
    #1;
    chk("falu valid", 32'(falu_wb.valid), 32'(gl && ok));
    if (gl && ok) chk("falu data", falu_wb.data, r);
    chk("status word", 32'(psw), 32'(p));
  endtask
  task automatic pw(input logic [5:0] v);
    @(posedge clock);
    psw_wr <= 1'b1;
    psw_wflags <= v;
    @(posedge clock);
    psw_wr <= 1'b0;
    #1;
    chk("status write", 32'(psw), 32'(v));
  endtask
  task automatic t_reset;
    @(posedge clock);
    #1;
    chk("reset alu", 32'(alu_wb.valid), 32'h0);
    chk("reset falu", 32'(falu_wb.valid), 32'h0);
    chk("reset flags", 32'(psw), 32'(PSW_FLAGS_RST));
    @(posedge clock);
    resetn <= 1'b1;
  endtask
  task automatic t_compare;
    cmp(OPC_UGEQ, 3'h1, 1'b1, 32'h3, 32'h4, 7'h01, 1'b0);
    cmp(OPC_UGEQ, 3'h2, 1'b1, 32'h8000_0000, 32'h8000_0000, 7'h02, 1'b1);
    cmp(OPC_UGEQ, 3'h3, 1'b1, 32'h4, 32'h8000_0000, 7'h03, 1'b0);
    cmp(OPC_UGEQ, 3'h4, 1'b0, 32'h100, 32'h3, 7'h04, 1'b0);
    cmp(OPC_UGEQI, 3'h5, 1'b1, 32'h3, 32'h0, 7'h03, 1'b1);
    cmp(OPC_UGEQI, 3'h1, 1'b1, 32'h3, 32'h0, 7'h04, 1'b0);
    cmp(OPC_UGEQI, 3'h2, 1'b1, 32'h8000_0000, 32'h0, 7'h7F, 1'b1);
    cmp(OPC_UGTR, 3'h3, 1'b1, 32'h8000_0000, 32'h8000_0000, 7'h05, 1'b0);
    cmp(OPC_UGTR, 3'h4, 1'b1, 32'h8000_0000, 32'h4, 7'h06, 1'b1);
    cmp(OPC_UGTR, 3'h5, 1'b1, 32'h3, 32'h4, 7'h07, 1'b0);
    cmp(OPC_UGTRI, 3'h1, 1'b1, 32'h3, 32'h0, 7'h02, 1'b1);
    cmp(OPC_UGTRI, 3'h5, 1'b1, 32'h3, 32'h0, 7'h03, 1'b0);
    cmp(OPC_UGTRI, 3'h2, 1'b0, 32'h100, 32'h0, 7'h3F, 1'b0);
    cmp(OPC_UGTRI, 3'h3, 1'b1, 32'h8000_0000, 32'h0, 7'h7F, 1'b1);
    issue_model_inst.send(op(OPC_UGTRI, 3'h0, 1'b1, 32'h9, 32'h0, 7'h01));
    #1;
    chk("bad slot flag", 32'(illegal_slot), 32'h1);
    chk("bad slot wb", 32'(alu_wb.valid), 32'h0);
  endtask
  // unguarded op must write; clock enable low must hold the pulse
  task automatic t_freeze;
    issue_t o;
    o = op(OPC_UGTR, 3'h1, 1'b1, 32'h5, 32'h4, 7'h08);
    o.guard_en = 1'b0;
    o.guard_lsb = 1'b0;
    issue_model_inst.send(o);
    ce <= 1'b0;
    #1;
    chk("unguarded wb", 32'(alu_wb.valid), 32'h1);
    chk("unguarded data", alu_wb.data, 32'h1);
    @(posedge clock);
    ce <= 1'b1;
    #1;
    chk("frozen wb", 32'(alu_wb.valid), 32'h1);
    @(posedge clock);
    #1;
    chk("released wb", 32'(alu_wb.valid), 32'h0);
  endtask
  task automatic t_float;
    fop(OPC_UFLOATRZFLAGS, 3'h1, 1'b1, 32'hFFFF_FFFF, 32'h02, 6'h00);
    fop(OPC_UFLOATRZFLAGS, 3'h4, 1'b1, 32'h8000_0000, 32'h00, 6'h00);
    fop(OPC_UFLOATRZFLAGS, 3'h4, 1'b0, 32'hFFFF_FFFD, 32'h02, 6'h00);
    fop(OPC_UFLOATRZFLAGS, 3'h2, 1'b1, 32'hFFFF_FFFF, 32'h02, 6'h00);
    fop(OPC_UFLOATRZ, 3'h1, 1'b1, 32'h7FFF_FFFF, 32'h4EFF_FFFF, 6'h02);
    fop(OPC_UFLOATRZ, 3'h4, 1'b1, 32'h3, 32'h4040_0000, 6'h02);
    fop(OPC_UFLOATRZ, 3'h1, 1'b0, 32'h7FFF_FFF1, 32'h0, 6'h02);
    fop(OPC_UFLOATRZFLAGS, 3'h1, 1'b1, 32'h7FFF_FFF1, 32'h02, 6'h02);
    fop(OPC_UFLOATRZ, 3'h4, 1'b1, 32'hFFFF_FFFF, 32'h4F7F_FFFF, 6'h02);
    fop(OPC_UFLOATRZFLAGS, 3'h1, 1'b1, 32'h3, 32'h00, 6'h02);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    t_reset;
    t_compare;
    t_freeze;
    t_float;
    pw(6'h00);
    pw(6'h20);
    final_report;
  end
endmodule
